// *** pfsm_pad_mux.sv ***
// pad function select mux: select decode, routing, swing and pull control
`timescale 1ns/100ps
`default_nettype none
module pfsm_pad_mux
  import pfsm_pkg::*;
#(
  parameter int SEL_W = 3,
  parameter logic [PFSM_NFN-1:0] DBG_FN_MASK = 5'h00,
  parameter bit MULTIV = 1'b0,
  parameter bit TIMER_PAD = 1'b0
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [SEL_W-1:0]     function_select_field,
  input  wire logic                 wake_pull_config_pin,
  input  wire logic                 reset_active,
  input  wire logic [PFSM_NFN-1:0]  fn_out,
  input  wire logic [PFSM_NFN-1:0]  fn_oe,
  input  wire logic                 pad_in,
  output logic                      pad_out,
  output logic                      pad_oe,
  output logic [PFSM_NFN-1:0]       fn_in,
  output logic                      pad_low_swing,
  output logic                      pad_pull_en,
  output logic                      pad_pull_up
);
  ////////////////////////////////////////////////////////////////////////
  pfsm_fn_t fn_d;
  pfsm_fn_t fn_q;
  logic     wake_q;
  logic     pad_out_q;
  logic     pad_oe_q;
  logic [PFSM_NFN-1:0] fn_in_q;
  // select widened to four bits so every width branch indexes in range
  logic [3:0]          sel_w;

  assign sel_w = 4'(function_select_field);

  // decode; any multi-bit code degrades to gpio so pads never fight
  always_comb begin
    fn_d = PFSM_FN_GPIO;
    if (SEL_W == 2) begin
      if (sel_w[1:0] == PFSM_SEL2_PRI) begin
        fn_d = PFSM_FN_PRI;
      end
    end else if (SEL_W == 3) begin
      // middle bit decodes to the first alternate on every three-bit pad
      if (sel_w[2:0] == PFSM_SEL3_PRI) begin
        fn_d = PFSM_FN_PRI;
      end else if (sel_w[2:0] == PFSM_SEL3_ALT1) begin
        fn_d = PFSM_FN_ALT1;
      end else if (sel_w[2:0] == PFSM_SEL3_ALT2) begin
        fn_d = PFSM_FN_ALT2;
      end
    end else begin
      if (sel_w == PFSM_SEL4_PRI) begin
        fn_d = PFSM_FN_PRI;
      end else if (sel_w == PFSM_SEL4_ALT1) begin
        fn_d = PFSM_FN_ALT1;
      end else if (sel_w == PFSM_SEL4_ALT2) begin
        fn_d = PFSM_FN_ALT2;
      end else if (sel_w == PFSM_SEL4_ALT3) begin
        fn_d = PFSM_FN_ALT3;
      end
    end
  end

  // registered selection; reset parks the pad as gpio
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fn_q <= PFSM_FN_GPIO;
    end else begin
      fn_q <= fn_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // routing: only the selected source drives, others see zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
      fn_in_q   <= '0;
    end else begin
      pad_out_q <= |(fn_out & fn_q);
      pad_oe_q  <= |(fn_oe & fn_q);
      fn_in_q   <= pad_in ? PFSM_NFN'(fn_q) : '0;
    end
  end
  assign pad_out = pad_out_q;
  assign pad_oe  = pad_oe_q;
  assign fn_in   = fn_in_q;

  // swing follows the selection, trace pins need the low-voltage levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_low_swing <= 1'b0;
    end else begin
      pad_low_swing <= MULTIV && ((fn_d & DBG_FN_MASK) != '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-pull value latched while reset is held, kept after release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= PFSM_WAKE_RST;
    end else if (reset_active) begin
      wake_q <= wake_pull_config_pin;
    end
  end

  // pull applied during and after reset on timer pads
  assign pad_pull_en = TIMER_PAD;
  assign pad_pull_up = TIMER_PAD && (reset_active ? wake_pull_config_pin
                                                  : wake_q);

  ////////////////////////////////////////////////////////////////////////
  property p_onehot_sel;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> $onehot(fn_q);
  endproperty
  a_onehot_sel: assert property (p_onehot_sel)
    else $error("selection not one-hot");

  property p_multi_gpio;
    @(posedge ref_clk) disable iff (!rst_n)
      !$onehot0(function_select_field) |=> fn_q == PFSM_FN_GPIO;
  endproperty
  a_multi_gpio: assert property (p_multi_gpio)
    else $error("multi-bit code not gpio");

  property p_zero_gpio;
    @(posedge ref_clk) disable iff (!rst_n)
      function_select_field == '0 |=> fn_q == PFSM_FN_GPIO;
  endproperty
  a_zero_gpio: assert property (p_zero_gpio)
    else $error("zero code not gpio");

  property p_pri;
    @(posedge ref_clk) disable iff (!rst_n)
      function_select_field == SEL_W'(1) |=> fn_q == PFSM_FN_PRI;
  endproperty
  a_pri: assert property (p_pri)
    else $error("code one not primary");

  property p_top_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      (SEL_W > 2 && function_select_field == SEL_W'(4))
        |=> fn_q == PFSM_FN_ALT2;
  endproperty
  a_top_bit: assert property (p_top_bit)
    else $error("code 100 not second alternate");

  property p_alt3;
    @(posedge ref_clk) disable iff (!rst_n)
      (SEL_W == 4 && function_select_field == SEL_W'(8))
        |=> fn_q == PFSM_FN_ALT3;
  endproperty
  a_alt3: assert property (p_alt3)
    else $error("code 1000 not third alternate");

  property p_swing;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> pad_low_swing == (MULTIV && ((fn_q & DBG_FN_MASK) != '0));
  endproperty
  a_swing: assert property (p_swing)
    else $error("swing mode wrong");

  property p_drive;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> pad_oe == |($past(fn_oe) & $past(fn_q));
  endproperty
  a_drive: assert property (p_drive)
    else $error("pad enable from wrong source");

  property p_pull;
    @(posedge ref_clk) disable iff (!rst_n)
      (TIMER_PAD && $fell(reset_active))
        |-> pad_pull_up == $past(wake_pull_config_pin);
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull direction lost after reset");

  // routing checked against the selection held one edge earlier
  property p_route_out;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> pad_out == |($past(fn_out) & $past(fn_q));
  endproperty
  a_route_out: assert property (p_route_out)
    else $error("pad value from wrong source");

  property p_route_in;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> fn_in ==
        (PFSM_NFN'($past(fn_q)) & {PFSM_NFN{$past(pad_in)}});
  endproperty
  a_route_in: assert property (p_route_in)
    else $error("pad input routed to wrong function");

  property p_onehot_in;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> $onehot0(fn_in);
  endproperty
  a_onehot_in: assert property (p_onehot_in)
    else $error("pad input reaches two functions");

  // outside reset the pull must not wander with the strap pin
  property p_pull_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (TIMER_PAD && !reset_active && !$past(reset_active))
        |-> $stable(pad_pull_up);
  endproperty
  a_pull_hold: assert property (p_pull_hold)
    else $error("pull direction moved outside reset");

  c_pri:  cover property (@(posedge ref_clk) fn_q == PFSM_FN_PRI);
  c_alt2: cover property (@(posedge ref_clk) fn_q == PFSM_FN_ALT2);
  c_low:  cover property (@(posedge ref_clk) pad_low_swing);
  c_up:   cover property (@(posedge ref_clk) $fell(reset_active) && wake_q);
  c_alt3: cover property (@(posedge ref_clk) fn_q == PFSM_FN_ALT3);
endmodule
`default_nettype wire

// *** pfsm_pkg.sv ***
// constants and types for the pad function select mux
package pfsm_pkg;
  // function-select codes, 2-bit pads
  localparam logic [1:0] PFSM_SEL2_GPIO = 2'h0;
  localparam logic [1:0] PFSM_SEL2_PRI  = 2'h1;
  // function-select codes, 3-bit pads
  localparam logic [2:0] PFSM_SEL3_GPIO = 3'h0;
  localparam logic [2:0] PFSM_SEL3_PRI  = 3'h1;
  localparam logic [2:0] PFSM_SEL3_ALT1 = 3'h2;
  localparam logic [2:0] PFSM_SEL3_ALT2 = 3'h4;
  // function-select codes, 4-bit pads
  localparam logic [3:0] PFSM_SEL4_GPIO = 4'h0;
  localparam logic [3:0] PFSM_SEL4_PRI  = 4'h1;
  localparam logic [3:0] PFSM_SEL4_ALT1 = 4'h2;
  localparam logic [3:0] PFSM_SEL4_ALT2 = 4'h4;
  localparam logic [3:0] PFSM_SEL4_ALT3 = 4'h8;
  // decoded function, one-hot
  typedef enum logic [4:0] {
    PFSM_FN_GPIO = 5'h01,
    PFSM_FN_PRI  = 5'h02,
    PFSM_FN_ALT1 = 5'h04,
    PFSM_FN_ALT2 = 5'h08,
    PFSM_FN_ALT3 = 5'h10
  } pfsm_fn_t;
  // index of each function in a pad's source vectors
  localparam int PFSM_IDX_GPIO = 0;
  localparam int PFSM_IDX_PRI  = 1;
  localparam int PFSM_IDX_ALT1 = 2;
  localparam int PFSM_IDX_ALT2 = 3;
  localparam int PFSM_IDX_ALT3 = 4;
  localparam int PFSM_NFN      = 5;
  // wake-pull values and pull-state reset
  localparam logic PFSM_WAKE_DOWN = 1'b0;
  localparam logic PFSM_WAKE_UP   = 1'b1;
  localparam logic PFSM_WAKE_RST  = 1'b0;
endpackage

// *** test_pad_function_select_mux.sv ***
// self-checking bench for the pad function select mux
`timescale 1ns/100ps
`default_nettype none
module test_pad_function_select_mux;
  import pfsm_pkg::*;
  // alt1 and alt2 act as scan/trace functions here
  localparam logic [4:0] DBG = 5'h0C;
  // on the five-function pad only the third alternate is a trace function
  localparam logic [4:0] DBG4 = 5'h10;
  logic       ref_clk;
  logic       rst_n;
  logic       strap;
  logic       rst_act;
  logic       pad_in;
  logic       pad_out;
  logic       pad_oe;
  logic       low_sw;
  logic       pull_en;
  logic       pull_up;
  logic [2:0] sel;
  logic [4:0] fo;
  logic [4:0] foe;
  logic [4:0] fn_in;
  logic [1:0] sel2;
  logic [3:0] sel4;
  logic       pad_out2;
  logic       pad_oe2;
  logic       low_sw2;
  logic       pull_en2;
  logic       pull_up2;
  logic [4:0] fn_in2;
  logic       pad_out4;
  logic       pad_oe4;
  logic       low_sw4;
  logic       pull_en4;
  logic       pull_up4;
  logic [4:0] fn_in4;
  int         err_total;
  int         total_checks;
  pfsm_pad_mux #(.SEL_W(3), .DBG_FN_MASK(DBG), .MULTIV(1'b1),
    .TIMER_PAD(1'b1)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .function_select_field(sel),
    .wake_pull_config_pin(strap), .reset_active(rst_act), .fn_out(fo),
    .fn_oe(foe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .fn_in(fn_in), .pad_low_swing(low_sw), .pad_pull_en(pull_en),
    .pad_pull_up(pull_up));
  // two-function pad, single voltage, so its flagged function stays high
  pfsm_pad_mux #(.SEL_W(2), .DBG_FN_MASK(5'h02), .MULTIV(1'b0),
    .TIMER_PAD(1'b0)) uut_w2 (
    .ref_clk(ref_clk), .rst_n(rst_n), .function_select_field(sel2),
    .wake_pull_config_pin(strap), .reset_active(rst_act), .fn_out(fo),
    .fn_oe(foe), .pad_in(pad_in), .pad_out(pad_out2), .pad_oe(pad_oe2),
    .fn_in(fn_in2), .pad_low_swing(low_sw2), .pad_pull_en(pull_en2),
    .pad_pull_up(pull_up2));
  // five-function multivoltage pad, no timer pull
  pfsm_pad_mux #(.SEL_W(4), .DBG_FN_MASK(DBG4), .MULTIV(1'b1),
    .TIMER_PAD(1'b0)) uut_w4 (
    .ref_clk(ref_clk), .rst_n(rst_n), .function_select_field(sel4),
    .wake_pull_config_pin(strap), .reset_active(rst_act), .fn_out(fo),
    .fn_oe(foe), .pad_in(pad_in), .pad_out(pad_out4), .pad_oe(pad_oe4),
    .fn_in(fn_in4), .pad_low_swing(low_sw4), .pad_pull_en(pull_en4),
    .pad_pull_up(pull_up4));
  ////////////////////////////////////////////////////////////////////////
  // expected function index; anything not one-hot lands on gpio
  function automatic int fn_idx(input int w, input logic [3:0] s);
    logic [3:0] m;
    m = s & 4'((1 << w) - 1);
    case (m)
      4'h1: return PFSM_IDX_PRI;
      4'h2: return (w > 2) ? PFSM_IDX_ALT1 : PFSM_IDX_GPIO;
      4'h4: return (w > 2) ? PFSM_IDX_ALT2 : PFSM_IDX_GPIO;
      4'h8: return (w > 3) ? PFSM_IDX_ALT3 : PFSM_IDX_GPIO;
      default: return PFSM_IDX_GPIO;
    endcase
  endfunction
  task chk(input logic [4:0] got, input logic [4:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // inputs held two edges so a two-deep pad path has settled too
  task step(input logic [3:0] s);
    int i;
    int j;
    int k;
    @(posedge ref_clk);
    sel <= s[2:0];
    sel2 <= s[1:0];
    sel4 <= s;
    fo <= 5'($urandom);
    foe <= 5'($urandom);
    pad_in <= 1'($urandom);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    i = fn_idx(3, s);
    j = fn_idx(2, s);
    k = fn_idx(4, s);
    chk({3'h0, pad_out, pad_oe}, {3'h0, fo[i], foe[i]});
    chk(fn_in, 5'(pad_in) << i);
    chk({4'h0, low_sw}, {4'h0, DBG[i]});
    chk({3'h0, pad_out2, pad_oe2}, {3'h0, fo[j], foe[j]});
    chk(fn_in2, 5'(pad_in) << j);
    chk({4'h0, low_sw2}, 5'h00);
    chk({3'h0, pad_out4, pad_oe4}, {3'h0, fo[k], foe[k]});
    chk(fn_in4, 5'(pad_in) << k);
    chk({4'h0, low_sw4}, {4'h0, DBG4[k]});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    complete_run;
  end
  initial begin
    rst_n = 1'b0;
    sel = 3'h0;
    fo = 5'h00;
    foe = 5'h00;
    pad_in = 1'b0;
    strap = 1'b0;
    rst_act = 1'b0;
    sel2 = 2'h0;
    sel4 = 4'h0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(92329));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // strap followed during reset, then held after it
    for (int v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      rst_act <= 1'b1;
      strap <= 1'(v);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({3'h0, pull_en, pull_up}, {4'h1, 1'(v)});
      chk({3'h0, pull_en2, pull_up2}, 5'h00);
      chk({3'h0, pull_en4, pull_up4}, 5'h00);
      @(posedge ref_clk);
      rst_act <= 1'b0;
      strap <= 1'(1 - v);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({3'h0, pull_en, pull_up}, {4'h1, 1'(v)});
    end
    // every code, legal and multi-bit, then random traffic
    for (int c = 0; c < 16; c++) step(4'(c));
    repeat (40) step(4'($urandom));
    complete_run;
  end
endmodule
`default_nettype wire
